// ---- src/uer_len_mem.sv ----
// Byte-count store for the packets held in the receive FIFO slots
module uer_len_mem (
    input  wire logic  hclk,
    input  wire logic  hresetn,
    uer_mem_if.mem     mem
);
    logic [uer_pkg::LEN_W-1:0] slot_reg [uer_pkg::SLOTS];

    genvar gi;
    generate
        for (gi = 0; gi < uer_pkg::SLOTS; gi++)
        begin : g_slot
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    slot_reg[gi] <= '0;
                else if (mem.wr_en && (mem.wr_idx == 1'(gi)))
                    slot_reg[gi] <= mem.wr_data;
            end
        end
    endgenerate

    // Registered read port keeps the bus read path short
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mem.rd_data <= '0;
        else
            mem.rd_data <= slot_reg[mem.rd_idx];
    end
endmodule : uer_len_mem

// ---- src/uer_mem_if.sv ----
// Carrier between the receive control logic and the packet length store
interface uer_mem_if;
    logic                        wr_en;
    logic                        wr_idx;
    logic [uer_pkg::LEN_W-1:0]   wr_data;
    logic                        rd_idx;
    logic [uer_pkg::LEN_W-1:0]   rd_data;

    modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
    modport mem  (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : uer_mem_if

// ---- src/uer_pkg.sv ----
// Constants and types shared by the endpoint receive status block
package uer_pkg;
    localparam logic [7:0]  ADDR_CSR1      = 8'h00;
    localparam logic [7:0]  ADDR_OTG       = 8'h04;
    localparam logic [7:0]  ADDR_CFG       = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h10;
    localparam logic [7:0]  ADDR_HEAD_LEN  = 8'h14;

    localparam int          CSR1_FLAG18    = 18;
    localparam int          CSR1_FULL      = 17;
    localparam int          CSR1_RXPKT     = 16;
    localparam int          CSR1_FACTOR_LO = 11;
    localparam int          CSR1_MAXP_LO   = 0;
    localparam int          OTG_RX_DBL     = 28;
    localparam int          OTG_RXSZ_LO    = 24;
    localparam int          OTG_TX_DBL     = 20;
    localparam int          OTG_TXSZ_LO    = 16;
    localparam int          CFG_HOST       = 0;
    localparam int          CFG_TYPE_LO    = 1;
    localparam int          CFG_TX_PAY_LO  = 16;
    localparam int          IRQ_RXPKT      = 0;
    localparam int          IRQ_NODATA     = 1;
    localparam int          IRQ_OVERRUN    = 2;

    localparam int          FACTOR_W       = 5;
    localparam int          MAXP_W         = 11;
    localparam int          SZ_W           = 4;
    localparam int          LEN_W          = 13;
    localparam int          PAYLOAD_W      = 17;
    localparam int          FIFO_BYTES_W   = 14;
    localparam int          SLOTS          = 2;
    localparam int          IRQ_W          = 3;

    localparam logic [SZ_W-1:0]         SZ_MAX_CODE    = 4'h9;
    localparam logic [FIFO_BYTES_W-1:0] SZ_BASE_BYTES  = 14'h0008;
    localparam logic [1:0]              NODATA_LIMIT   = 2'h3;

    localparam logic [31:0] CSR1_RESET     = 32'h0000_0000;
    localparam logic [31:0] OTG_RESET      = 32'h0000_0000;
    localparam logic [31:0] CFG_RESET      = 32'h0000_0000;

    typedef enum logic [1:0] {
        UER_XFER_CTRL,
        UER_XFER_ISO,
        UER_XFER_BULK,
        UER_XFER_INTR
    } uer_xfer_t;
endpackage : uer_pkg

// ---- src/uer_rx_ctrl.sv ----
// Endpoint receive status, payload sizing and FIFO sizing with AHB-Lite registers
// Overview of operation
// - Device mode, isochronous: OUT packet arriving while the FIFO is full sets bit 18.
// - Bit 18 reads zero in device mode unless the endpoint is isochronous.
// - Host mode: three receive attempts without data set bit 18 and interrupt.
// - Host-mode bit 18 reads zero when the endpoint is isochronous.
// - Bit 17 reads one exactly when occupancy reaches capacity: one slot, or both slots with bit 28 set.
// - Arriving packet sets bit 16 and interrupts; software clears after unloading.
// - Payload equals max transmit payload times multiplier field plus one.
// - Eleven-bit max receive payload bounds bytes accepted per transaction.
// - Receive double buffering bit 28 doubles receive FIFO capacity.
// - Receive size code gives 8 bytes shifted by code; codes above 9 reserved.
// - Transmit double buffering bit 20 doubles transmit FIFO capacity.
// - Bits 31-29 of the OTG control register always read zero.
module uer_rx_ctrl (
    input  wire logic                            hclk,
    input  wire logic                            hresetn,
    input  wire logic                            hsel,
    input  wire logic [31:0]                     haddr,
    input  wire logic [1:0]                      htrans,
    input  wire logic                            hwrite,
    input  wire logic [2:0]                      hsize,
    input  wire logic [31:0]                     hwdata,
    input  wire logic                            hready,
    output logic                                 hreadyout,
    output logic [31:0]                          hrdata,
    output logic                                 hresp,
    input  wire logic                            rx_pkt_valid,
    input  wire logic [uer_pkg::LEN_W-1:0]       rx_pkt_bytes,
    input  wire logic                            rx_no_data,
    output logic                                 rx_pkt_accept,
    output logic                                 rx_pkt_drop,
    output logic [uer_pkg::PAYLOAD_W-1:0]        payload_bytes,
    output logic [uer_pkg::FIFO_BYTES_W-1:0]     rx_fifo_bytes,
    output logic [uer_pkg::FIFO_BYTES_W-1:0]     tx_fifo_bytes,
    output logic                                 irq
);
    logic                            flag18_reg;
    logic                            rx_flag_reg;
    logic [uer_pkg::FACTOR_W-1:0]    factor_reg;
    logic [uer_pkg::MAXP_W-1:0]      rx_maxp_reg;
    logic                            rx_dpb_reg;
    logic [uer_pkg::SZ_W-1:0]        rx_sz_reg;
    logic                            tx_dpb_reg;
    logic [uer_pkg::SZ_W-1:0]        tx_sz_reg;
    logic                            host_mode_reg;
    uer_pkg::uer_xfer_t              xfer_reg;
    logic [uer_pkg::MAXP_W-1:0]      tx_maxp_reg;
    logic [uer_pkg::IRQ_W-1:0]       irq_stat_reg;
    logic [uer_pkg::IRQ_W-1:0]       irq_mask_reg;
    logic [1:0]                      occ_reg;
    logic                            head_reg;
    logic [1:0]                      miss_reg;
    logic                            wr_pend_reg;
    logic [7:0]                      wr_addr_reg;

    logic                            is_iso;
    logic                            slots_full;
    logic [1:0]                      capacity;
    logic                            addr_phase;
    logic                            do_write;
    logic                            irq_read;
    logic                            size_ok;
    logic                            arrive_ok;
    logic                            overrun_evt;
    logic                            nodata_evt;
    logic                            unload;
    logic                            flag18_view;
    logic [31:0]                     csr1_view;
    logic [31:0]                     otg_view;
    logic [31:0]                     cfg_view;
    logic [31:0]                     rd_mux;
    logic [uer_pkg::IRQ_W-1:0]       irq_events;

    uer_mem_if mem_bus ();

    uer_len_mem u_len_mem (
        .hclk    (hclk),
        .hresetn (hresetn),
        .mem     (mem_bus.mem)
    );

    assign is_iso      = (xfer_reg == uer_pkg::UER_XFER_ISO);
    assign capacity    = rx_dpb_reg ? 2'h2 : 2'h1;
    assign slots_full  = (occ_reg == capacity);
    assign addr_phase  = hsel && hready && htrans[1];
    assign do_write    = wr_pend_reg;
    assign irq_read    = addr_phase && !hwrite && (haddr[7:0] == uer_pkg::ADDR_IRQ_STAT);

    // Packets longer than the programmed maximum are refused
    assign size_ok     = (rx_pkt_bytes <= uer_pkg::LEN_W'(rx_maxp_reg));
    assign arrive_ok   = rx_pkt_valid && size_ok && !slots_full;
    assign overrun_evt = rx_pkt_valid && slots_full && !host_mode_reg && is_iso;
    assign nodata_evt  = rx_no_data && host_mode_reg && !is_iso
                         && (miss_reg == (uer_pkg::NODATA_LIMIT - 2'h1));

    // Unload is signalled by software writing zero to the received flag
    assign unload      = do_write && (wr_addr_reg == uer_pkg::ADDR_CSR1)
                         && !hwdata[uer_pkg::CSR1_RXPKT] && rx_flag_reg;

    // Bit 18 means overrun in device mode and no-data error in host mode
    assign flag18_view = host_mode_reg ? (flag18_reg && !is_iso)
                                       : (flag18_reg && is_iso);

    assign irq_events  = {overrun_evt, nodata_evt, arrive_ok};

    always_comb
    begin
        csr1_view = '0;
        csr1_view[uer_pkg::CSR1_FLAG18] = flag18_view;
        csr1_view[uer_pkg::CSR1_FULL]   = slots_full;
        csr1_view[uer_pkg::CSR1_RXPKT]  = rx_flag_reg;
        csr1_view[uer_pkg::CSR1_FACTOR_LO +: uer_pkg::FACTOR_W] = factor_reg;
        csr1_view[uer_pkg::CSR1_MAXP_LO +: uer_pkg::MAXP_W] = rx_maxp_reg;
        otg_view = '0;
        otg_view[uer_pkg::OTG_RX_DBL] = rx_dpb_reg;
        otg_view[uer_pkg::OTG_RXSZ_LO +: uer_pkg::SZ_W] = rx_sz_reg;
        otg_view[uer_pkg::OTG_TX_DBL] = tx_dpb_reg;
        otg_view[uer_pkg::OTG_TXSZ_LO +: uer_pkg::SZ_W] = tx_sz_reg;
        cfg_view = '0;
        cfg_view[uer_pkg::CFG_HOST] = host_mode_reg;
        cfg_view[uer_pkg::CFG_TYPE_LO +: 2] = xfer_reg;
        cfg_view[uer_pkg::CFG_TX_PAY_LO +: uer_pkg::MAXP_W] = tx_maxp_reg;
        case (haddr[7:0])
            uer_pkg::ADDR_CSR1:     rd_mux = csr1_view;
            uer_pkg::ADDR_OTG:      rd_mux = otg_view;
            uer_pkg::ADDR_CFG:      rd_mux = cfg_view;
            uer_pkg::ADDR_IRQ_STAT: rd_mux = {29'h0, irq_stat_reg};
            uer_pkg::ADDR_IRQ_MASK: rd_mux = {29'h0, irq_mask_reg};
            uer_pkg::ADDR_HEAD_LEN: rd_mux = {19'h0, mem_bus.rd_data};
            default:                rd_mux = 32'h0000_0000;
        endcase
    end

    // Zero-wait slave: read data is captured in the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            hrdata      <= 32'h0000_0000;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end
        else
        begin
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase)
                wr_addr_reg <= haddr[7:0];
            if (addr_phase && !hwrite)
                hrdata <= rd_mux;
        end
    end

    // Control fields written by software
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            factor_reg    <= uer_pkg::CSR1_RESET[uer_pkg::CSR1_FACTOR_LO +: uer_pkg::FACTOR_W];
            rx_maxp_reg   <= uer_pkg::CSR1_RESET[uer_pkg::CSR1_MAXP_LO +: uer_pkg::MAXP_W];
            rx_dpb_reg    <= uer_pkg::OTG_RESET[uer_pkg::OTG_RX_DBL];
            rx_sz_reg     <= uer_pkg::OTG_RESET[uer_pkg::OTG_RXSZ_LO +: uer_pkg::SZ_W];
            tx_dpb_reg    <= uer_pkg::OTG_RESET[uer_pkg::OTG_TX_DBL];
            tx_sz_reg     <= uer_pkg::OTG_RESET[uer_pkg::OTG_TXSZ_LO +: uer_pkg::SZ_W];
            host_mode_reg <= uer_pkg::CFG_RESET[uer_pkg::CFG_HOST];
            xfer_reg      <= uer_pkg::UER_XFER_CTRL;
            tx_maxp_reg   <= uer_pkg::CFG_RESET[uer_pkg::CFG_TX_PAY_LO +: uer_pkg::MAXP_W];
            irq_mask_reg  <= '0;
        end
        else if (do_write)
        begin
            case (wr_addr_reg)
                uer_pkg::ADDR_CSR1:
                begin
                    factor_reg  <= hwdata[uer_pkg::CSR1_FACTOR_LO +: uer_pkg::FACTOR_W];
                    rx_maxp_reg <= hwdata[uer_pkg::CSR1_MAXP_LO +: uer_pkg::MAXP_W];
                end
                uer_pkg::ADDR_OTG:
                begin
                    rx_dpb_reg <= hwdata[uer_pkg::OTG_RX_DBL];
                    rx_sz_reg  <= hwdata[uer_pkg::OTG_RXSZ_LO +: uer_pkg::SZ_W];
                    tx_dpb_reg <= hwdata[uer_pkg::OTG_TX_DBL];
                    tx_sz_reg  <= hwdata[uer_pkg::OTG_TXSZ_LO +: uer_pkg::SZ_W];
                end
                uer_pkg::ADDR_CFG:
                begin
                    host_mode_reg <= hwdata[uer_pkg::CFG_HOST];
                    xfer_reg      <= uer_pkg::uer_xfer_t'(hwdata[uer_pkg::CFG_TYPE_LO +: 2]);
                    tx_maxp_reg   <= hwdata[uer_pkg::CFG_TX_PAY_LO +: uer_pkg::MAXP_W];
                end
                uer_pkg::ADDR_IRQ_MASK: irq_mask_reg <= hwdata[uer_pkg::IRQ_W-1:0];
                default:                irq_mask_reg <= irq_mask_reg;
            endcase
        end
    end

    // Hardware flags: set wins over a zero write, a one write leaves them
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            flag18_reg  <= 1'b0;
            rx_flag_reg <= 1'b0;
        end
        else
        begin
            if (overrun_evt || nodata_evt)
                flag18_reg <= 1'b1;
            else if (do_write && (wr_addr_reg == uer_pkg::ADDR_CSR1)
                     && !hwdata[uer_pkg::CSR1_FLAG18])
                flag18_reg <= 1'b0;
            // A second buffered packet keeps the flag up after an unload
            if (arrive_ok || (unload && (occ_reg > 2'h1)))
                rx_flag_reg <= 1'b1;
            else if (unload)
                rx_flag_reg <= 1'b0;
        end
    end

    // Slot occupancy and length store bookkeeping
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            occ_reg  <= 2'h0;
            head_reg <= 1'b0;
        end
        else
        begin
            case ({arrive_ok, unload})
                2'b10:   occ_reg <= occ_reg + 2'h1;
                2'b01:   occ_reg <= occ_reg - 2'h1;
                default: occ_reg <= occ_reg;
            endcase
            if (unload && rx_dpb_reg)
                head_reg <= !head_reg;
        end
    end

    assign mem_bus.wr_en   = arrive_ok;
    assign mem_bus.wr_idx  = rx_dpb_reg ? (head_reg ^ (occ_reg != 2'h0)) : 1'b0;
    assign mem_bus.wr_data = rx_pkt_bytes;
    assign mem_bus.rd_idx  = rx_dpb_reg ? head_reg : 1'b0;

    // Counts consecutive empty attempts; any data packet restarts it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            miss_reg <= 2'h0;
        else if (rx_pkt_valid || !host_mode_reg || is_iso || nodata_evt)
            miss_reg <= 2'h0;
        else if (rx_no_data)
            miss_reg <= miss_reg + 2'h1;
    end

    // Interrupt status is sticky and cleared by reading it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_stat_reg <= '0;
            irq          <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= (irq_read ? '0 : irq_stat_reg) | irq_events;
            irq          <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Sizing outputs; reserved size codes report zero bytes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            payload_bytes <= '0;
            rx_fifo_bytes <= '0;
            tx_fifo_bytes <= '0;
            rx_pkt_accept <= 1'b0;
            rx_pkt_drop   <= 1'b0;
        end
        else
        begin
            payload_bytes <= uer_pkg::PAYLOAD_W'(tx_maxp_reg * (factor_reg + 6'h01));
            rx_fifo_bytes <= (rx_sz_reg > uer_pkg::SZ_MAX_CODE) ? '0
                           : (uer_pkg::SZ_BASE_BYTES << rx_sz_reg) << rx_dpb_reg;
            tx_fifo_bytes <= (tx_sz_reg > uer_pkg::SZ_MAX_CODE) ? '0
                           : (uer_pkg::SZ_BASE_BYTES << tx_sz_reg) << tx_dpb_reg;
            rx_pkt_accept <= arrive_ok;
            rx_pkt_drop   <= rx_pkt_valid && !arrive_ok;
        end
    end

    chk_overrun_sets: assert property (@(posedge hclk) disable iff (!hresetn)
        overrun_evt |=> flag18_reg)
        else $error("overrun did not set flag");
    chk_bulk_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (!host_mode_reg && !is_iso) |-> !csr1_view[uer_pkg::CSR1_FLAG18])
        else $error("flag 18 visible on non-iso device endpoint");
    chk_third_miss: assert property (@(posedge hclk) disable iff (!hresetn)
        (host_mode_reg && !is_iso && rx_no_data && !rx_pkt_valid && miss_reg == 2'h2)
        |=> (flag18_reg && irq_stat_reg[uer_pkg::IRQ_NODATA]))
        else $error("third empty attempt missed");
    chk_iso_host_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (host_mode_reg && is_iso) |-> !csr1_view[uer_pkg::CSR1_FLAG18])
        else $error("error flag visible on iso host endpoint");
    chk_full_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        csr1_view[uer_pkg::CSR1_FULL] == (occ_reg == (rx_dpb_reg ? 2'h2 : 2'h1)))
        else $error("full flag wrong");
    chk_rx_received: assert property (@(posedge hclk) disable iff (!hresetn)
        arrive_ok |=> (rx_flag_reg && rx_pkt_accept && irq_stat_reg[uer_pkg::IRQ_RXPKT]))
        else $error("packet arrival not flagged");
    chk_payload_calc: assert property (@(posedge hclk) disable iff (!hresetn)
        $stable(tx_maxp_reg) && $stable(factor_reg)
        |=> payload_bytes
            == uer_pkg::PAYLOAD_W'($past(tx_maxp_reg) * ($past(factor_reg) + 6'h01)))
        else $error("payload size wrong");
    chk_oversize_drop: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_pkt_valid && rx_pkt_bytes > uer_pkg::LEN_W'(rx_maxp_reg)) |=> rx_pkt_drop && !rx_pkt_accept)
        else $error("oversize packet accepted");
    chk_rx_size_dbl: assert property (@(posedge hclk) disable iff (!hresetn)
        ($stable(rx_sz_reg) && $stable(rx_dpb_reg) && rx_sz_reg == 4'h9 && rx_dpb_reg)
        |=> rx_fifo_bytes == 14'h2000)
        else $error("rx double capacity wrong");
    chk_tx_size_dbl: assert property (@(posedge hclk) disable iff (!hresetn)
        ($stable(tx_sz_reg) && $stable(tx_dpb_reg) && tx_sz_reg == 4'h3 && tx_dpb_reg)
        |=> tx_fifo_bytes == 14'h0080)
        else $error("tx double capacity wrong");
    chk_otg_top_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        otg_view[31:29] == 3'h0)
        else $error("otg top bits nonzero");
    chk_one_write_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
        (do_write && wr_addr_reg == uer_pkg::ADDR_CSR1 && hwdata[uer_pkg::CSR1_FLAG18]
         && flag18_reg) |=> flag18_reg)
        else $error("writing one cleared the flag");
endmodule : uer_rx_ctrl

// ---- tb/uer_link_model.sv ----
// Link-side model that delivers data packets and empty receive attempts
module uer_link_model (
    input  wire logic                        hclk,
    output logic                             rx_pkt_valid,
    output logic [uer_pkg::LEN_W-1:0]        rx_pkt_bytes,
    output logic                             rx_no_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        rx_pkt_valid = 1'b0;
        rx_pkt_bytes = 13'h0000;
        rx_no_data   = 1'b0;
    end

    // Count is inverted after the pulse so a stale value never looks valid
    task automatic send(input logic [uer_pkg::LEN_W-1:0] n);
        @(posedge hclk);
        rx_pkt_valid <= 1'b1;
        rx_pkt_bytes <= n;
        @(posedge hclk);
        rx_pkt_valid <= 1'b0;
        rx_pkt_bytes <= ~n;
    endtask : send

    task automatic miss();
        @(posedge hclk);
        rx_no_data <= 1'b1;
        @(posedge hclk);
        rx_no_data <= 1'b0;
    endtask : miss
endmodule : uer_link_model

// ---- tb/usb_endpoint_rx_fifo_control_tb.sv ----
// Self-checking bench for the endpoint receive status block
`define CHK(nm, e, g) \
    begin \
        tests_run++; \
        if ((g) !== (e)) \
        begin \
            error_cnt++; \
            $display("ERROR %s exp %h got %h", nm, e, g); \
        end \
    end

module usb_endpoint_rx_fifo_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                               hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0]                        haddr, hwdata, hrdata, v, re;
    logic [1:0]                         htrans, le;
    logic [2:0]                         hsize;
    logic                               rx_pkt_valid, rx_no_data, rx_pkt_accept, rx_pkt_drop, irq;
    logic [uer_pkg::LEN_W-1:0]          rx_pkt_bytes;
    logic [uer_pkg::PAYLOAD_W-1:0]      payload_bytes;
    logic [uer_pkg::FIFO_BYTES_W-1:0]   rx_fifo_bytes, tx_fifo_bytes;
    logic                               rd_ph;
    logic [15:0]                        fld;
    logic [10:0]                        txp;
    logic [4:0]                         m;
    logic [7:0]                         ra;
    logic [31:0]                        eq[$];
    logic [7:0]                         aq[$];
    logic [1:0]                         lq[$];
    int                                 error_cnt = 0;
    int                                 tests_run = 0;

    assign hready = hreadyout;

    uer_rx_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_pkt_valid(rx_pkt_valid),
        .rx_pkt_bytes(rx_pkt_bytes), .rx_no_data(rx_no_data), .rx_pkt_accept(rx_pkt_accept),
        .rx_pkt_drop(rx_pkt_drop), .payload_bytes(payload_bytes), .rx_fifo_bytes(rx_fifo_bytes),
        .tx_fifo_bytes(tx_fifo_bytes), .irq(irq));

    uer_link_model link (.hclk(hclk), .rx_pkt_valid(rx_pkt_valid),
        .rx_pkt_bytes(rx_pkt_bytes), .rx_no_data(rx_no_data));

    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        eq.push_back(e);
        aq.push_back(a);
        bus(a, 1'b0, 32'h0000_0000);
    endtask : rd

    task automatic pkt(input logic [12:0] n, input logic ok);
        lq.push_back(ok ? 2'h2 : 2'h1);
        link.send(n);
    endtask : pkt

    function automatic logic [31:0] csr(input logic f18, input logic full, input logic pk);
        return {13'h0000, f18, full, pk, fld};
    endfunction : csr

    function automatic logic [13:0] fb(input logic [3:0] c, input logic d);
        return (c > 4'h9) ? 14'h0000 : ((14'h0008 << c) << d);
    endfunction : fb

    // Scoreboard: a read result is due in the data phase, a link answer on its pulse
    always @(posedge hclk) rd_ph <= hsel && htrans[1] && !hwrite && hready;

    always @(negedge hclk)
    begin
        if (rd_ph === 1'b1)
        begin
            re = eq.pop_front();
            ra = aq.pop_front();
            `CHK($sformatf("hrdata@%h", ra), re, hrdata)
            `CHK("hresp", 1'b0, hresp)
            `CHK("hreadyout", 1'b1, hreadyout)
        end
        if ((rx_pkt_accept | rx_pkt_drop) === 1'b1)
        begin
            le = lq.pop_front();
            `CHK("accept_drop", le, {rx_pkt_accept, rx_pkt_drop})
        end
    end

    initial
    begin
        #100000;
        error_cnt++;
        summarize();
    end

    initial
    begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0000_0000;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0000_0000;
        void'($urandom(31606));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rd(uer_pkg::ADDR_CSR1, 32'h0000_0000);
        rd(uer_pkg::ADDR_OTG, 32'h0000_0000);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0000_0000);
        for (int i = 0; i < 16; i++)
        begin
            v = {3'h7, i[0], i[3:0], 3'h7, ~i[0], 4'(15 - i), 16'hFFFF};
            wr(uer_pkg::ADDR_OTG, v);
            rd(uer_pkg::ADDR_OTG, v & 32'h1F1F_0000);
            `CHK("rx_fifo_bytes", fb(i[3:0], i[0]), rx_fifo_bytes)
            `CHK("tx_fifo_bytes", fb(4'(15 - i), ~i[0]), tx_fifo_bytes)
        end
        for (int k = 0; k < 4; k++)
        begin
            txp = 11'($urandom);
            m = (k == 0) ? 5'h1F : (k == 1) ? 5'h02 : 5'($urandom);
            fld = {m, 11'h040};
            wr(uer_pkg::ADDR_CFG, {5'h00, txp, 16'h0000});
            wr(uer_pkg::ADDR_CSR1, {16'h0000, fld});
            rd(uer_pkg::ADDR_CSR1, {16'h0000, fld});
            `CHK("payload_bytes", 17'(txp) * 17'(m + 6'h01), payload_bytes)
        end
        wr(uer_pkg::ADDR_OTG, 32'h0000_0000);
        wr(uer_pkg::ADDR_CFG, 32'h0000_0002);
        wr(uer_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
        pkt(13'h0041, 1'b0);
        pkt(13'h0040, 1'b1);
        rd(uer_pkg::ADDR_CSR1, csr(1'b0, 1'b1, 1'b1));
        rd(uer_pkg::ADDR_HEAD_LEN, 32'h0000_0040);
        pkt(13'h0008, 1'b0);
        rd(uer_pkg::ADDR_CSR1, csr(1'b1, 1'b1, 1'b1));
        `CHK("irq", 1'b1, irq)
        rd(uer_pkg::ADDR_IRQ_STAT, 32'h0000_0005);
        rd(uer_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        `CHK("irq", 1'b0, irq)
        wr(uer_pkg::ADDR_CSR1, csr(1'b1, 1'b0, 1'b1));
        rd(uer_pkg::ADDR_CSR1, csr(1'b1, 1'b1, 1'b1));
        wr(uer_pkg::ADDR_CSR1, csr(1'b0, 1'b0, 1'b0));
        rd(uer_pkg::ADDR_CSR1, csr(1'b0, 1'b0, 1'b0));
        wr(uer_pkg::ADDR_OTG, 32'h1000_0000);
        wr(uer_pkg::ADDR_CFG, 32'h0000_0004);
        wr(uer_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
        pkt(13'h0001, 1'b1);
        pkt(13'h0002, 1'b1);
        pkt(13'h0003, 1'b0);
        rd(uer_pkg::ADDR_CSR1, csr(1'b0, 1'b1, 1'b1));
        `CHK("irq", 1'b0, irq)
        rd(uer_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
        rd(uer_pkg::ADDR_HEAD_LEN, 32'h0000_0001);
        wr(uer_pkg::ADDR_CSR1, csr(1'b0, 1'b0, 1'b0));
        rd(uer_pkg::ADDR_CSR1, csr(1'b0, 1'b0, 1'b1));
        rd(uer_pkg::ADDR_HEAD_LEN, 32'h0000_0002);
        wr(uer_pkg::ADDR_CSR1, csr(1'b0, 1'b0, 1'b0));
        rd(uer_pkg::ADDR_CSR1, csr(1'b0, 1'b0, 1'b0));
        wr(uer_pkg::ADDR_CFG, 32'h0000_0005);
        wr(uer_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
        repeat (2) link.miss();
        rd(uer_pkg::ADDR_CSR1, csr(1'b0, 1'b0, 1'b0));
        link.miss();
        rd(uer_pkg::ADDR_CSR1, csr(1'b1, 1'b0, 1'b0));
        `CHK("irq", 1'b1, irq)
        rd(uer_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
        wr(uer_pkg::ADDR_CFG, 32'h0000_0003);
        rd(uer_pkg::ADDR_CSR1, csr(1'b0, 1'b0, 1'b0));
        wr(uer_pkg::ADDR_CFG, 32'h0000_0004);
        rd(uer_pkg::ADDR_CSR1, csr(1'b0, 1'b0, 1'b0));
        wr(uer_pkg::ADDR_CFG, 32'h0000_0002);
        rd(uer_pkg::ADDR_CSR1, csr(1'b1, 1'b0, 1'b0));
        wr(uer_pkg::ADDR_CSR1, csr(1'b0, 1'b0, 1'b0));
        rd(uer_pkg::ADDR_CSR1, csr(1'b0, 1'b0, 1'b0));
        wr(uer_pkg::ADDR_CFG, 32'h0000_0003);
        repeat (3) link.miss();
        rd(uer_pkg::ADDR_CSR1, csr(1'b0, 1'b0, 1'b0));
        summarize();
    end
endmodule : usb_endpoint_rx_fifo_control_tb
